/* rtl/outcfg_pkg.sv */
package outcfg_pkg;
    typedef struct packed {
        logic second_clock_disable;
        logic duty_stabiliser_enable;
        logic ddr_clock_phase_select;
        logic double_rate_disable;
        logic output_swing_select;
        logic edge_and_demux_select;
    } cfg_s;
    typedef struct packed {
        logic test_pattern_enable;
        logic termination_trim_disable;
        logic interleave_low_freq_enable;
    } ext_s;
    typedef struct packed {
        logic offset_negative;
        logic [7:0] offset_mag;
        logic [9:0] full_scale_mv;
    } chan_s;
    typedef struct packed {
        logic sample_clock_invert;
        logic [4:0] coarse_field;
        logic [2:0] intermediate_delay_field;
        logic [5:0] fine_field;
    } adj_s;
    // Link-facing bits, moved across as one word
    typedef struct packed {
        logic second_clock_disable;
        logic ddr_clock_phase_select;
        logic double_rate_disable;
        logic edge_and_demux_select;
        logic test_pattern_enable;
    } link_cfg_s;
    typedef enum logic [1:0] {CAL_IDLE, CAL_TRIM, CAL_CORE} cal_e;

    localparam cfg_s CFG_RESET = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    localparam ext_s EXT_RESET = '{1'b0, 1'b0, 1'b0};
    localparam logic [9:0] FS_MIN_MV = 10'h230;
    localparam logic [9:0] FS_MAX_MV = 10'h348;
    localparam logic [9:0] FS_RESET_MV = 10'h2BC;
    localparam chan_s CHAN_RESET = '{1'b0, 8'h00, FS_RESET_MV};
    localparam adj_s ADJ_RESET = '{1'b0, 5'h00, 3'h0, 6'h00};
    localparam int MID_STEP_PS = 11;
    localparam int MAX_DELAY_PS = 2100;
    // Pins start as strap high with reset edge and swing, so no step follows reset
    localparam logic [3:0] PIN_RESET = 4'h5;
    localparam link_cfg_s LINK_CFG_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    localparam logic [11:0] DELAY_RESET = 12'h000;
    localparam logic [7:0] CODE_MIN = 8'h00;
    localparam logic [7:0] CODE_MAX = 8'hFF;
endpackage

/* rtl/outcfg_regs.sv */
`timescale 1ns/100ps
module adc_output_config_regs #(
    parameter int COARSE_STEP_PS = 100,
    parameter int CAL_TRIM_CYCLES = 64,
    parameter int CAL_CORE_CYCLES = 256
) (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic LINK_CLK,
    input wire logic EXT_CTRL_STRAP_N,
    input wire logic OUTPUT_EDGE_PIN,
    input wire logic OUTPUT_SWING_PIN,
    input wire outcfg_pkg::cfg_s CFG_IN,
    input wire logic CFG_WRITE,
    input wire outcfg_pkg::ext_s EXT_IN,
    input wire logic EXT_WRITE,
    input wire outcfg_pkg::chan_s ICH_IN,
    input wire logic ICH_WRITE,
    input wire outcfg_pkg::chan_s QCH_IN,
    input wire logic QCH_WRITE,
    input wire outcfg_pkg::adj_s ADJ_IN,
    input wire logic ADJ_WRITE,
    input wire logic CAL_START,
    input wire logic EXT_CLK_SEL,
    input wire logic [7:0] I_SAMPLE,
    input wire logic [7:0] Q_SAMPLE,
    output logic DUTY_STAB_ON,
    output logic SWING_NORMAL,
    output logic LOW_FREQ_ADJ,
    output logic SAMPLE_CLK_INVERT,
    output logic [11:0] APERTURE_DELAY_PS,
    output logic [5:0] FINE_DELAY,
    output outcfg_pkg::chan_s I_CHAN,
    output outcfg_pkg::chan_s Q_CHAN,
    output logic SYNTH_POWER_DOWN,
    output logic CAL_BUSY,
    output logic TRIM_ACTIVE,
    output logic OCLK_A,
    output logic OCLK_B_OR,
    output logic OCLK_CENTRE,
    output logic [15:0] I_BUS,
    output logic [15:0] Q_BUS,
    output logic [1:0] OVR_IND
);
    import outcfg_pkg::*;

    // Delay sum is 13 bits wide, which bounds the coarse step
    if (COARSE_STEP_PS < 1 || CAL_TRIM_CYCLES < 1 || CAL_CORE_CYCLES < 1 ||
        CAL_TRIM_CYCLES > 65535 || CAL_CORE_CYCLES > 65535 ||
        COARSE_STEP_PS * 31 + 7 * MID_STEP_PS > 8191) begin : g_param_check
        $error("Parameter out of range");
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pin_s1_q, pin_s2_q;
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            pin_s1_q <= PIN_RESET;
            pin_s2_q <= PIN_RESET;
        end else begin
            pin_s1_q <= {EXT_CLK_SEL, OUTPUT_SWING_PIN, OUTPUT_EDGE_PIN, EXT_CTRL_STRAP_N};
            pin_s2_q <= pin_s1_q;
        end
    end
    logic pin_mode;
    assign pin_mode = pin_s2_q[0];

    // ------------------------------------------------------------
    // Applied register groups
    // ------------------------------------------------------------
    cfg_s cfg_q, cfg_d;
    ext_s ext_q, ext_d;
    chan_s ich_q, ich_d, qch_q, qch_d;
    adj_s adj_q, adj_d;

    function automatic chan_s clamp_fs(input chan_s c);
        chan_s r;
        r = c;
        if (c.full_scale_mv < FS_MIN_MV) begin
            r.full_scale_mv = FS_MIN_MV;
        end else if (c.full_scale_mv > FS_MAX_MV) begin
            r.full_scale_mv = FS_MAX_MV;
        end
        return r;
    endfunction

    always_comb begin
        cfg_d = CFG_WRITE ? CFG_IN : cfg_q;
        ext_d = EXT_WRITE ? EXT_IN : ext_q;
        ich_d = ICH_WRITE ? clamp_fs(ICH_IN) : ich_q;
        qch_d = QCH_WRITE ? clamp_fs(QCH_IN) : qch_q;
        adj_d = ADJ_WRITE ? ADJ_IN : adj_q;
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            cfg_q <= CFG_RESET;
            ext_q <= EXT_RESET;
            ich_q <= CHAN_RESET;
            qch_q <= CHAN_RESET;
            adj_q <= ADJ_RESET;
        end else begin
            cfg_q <= cfg_d;
            ext_q <= ext_d;
            ich_q <= ich_d;
            qch_q <= qch_d;
            adj_q <= adj_d;
        end
    end

    // ------------------------------------------------------------
    // Effective settings and analog-side outputs
    // ------------------------------------------------------------
    cfg_s eff;
    logic [12:0] delay_sum;
    logic [11:0] delay_d;
    link_cfg_s lcfg_src_d, lcfg_src_q;
    logic cfg_tog_d, cfg_tog_q;

    // Strap high hands edge and swing to the pins; rest stays at reset values
    always_comb begin
        eff = pin_mode ? CFG_RESET : cfg_q;
        if (pin_mode) begin
            eff.edge_and_demux_select = pin_s2_q[1];
            eff.output_swing_select = pin_s2_q[2];
        end
        delay_sum = 13'(adj_q.coarse_field * COARSE_STEP_PS) +
                    13'(adj_q.intermediate_delay_field * MID_STEP_PS);
        delay_d = (delay_sum > 13'(MAX_DELAY_PS)) ? 12'(MAX_DELAY_PS) : delay_sum[11:0];
        lcfg_src_d = '{eff.second_clock_disable, eff.ddr_clock_phase_select,
                       eff.double_rate_disable, eff.edge_and_demux_select,
                       ext_q.test_pattern_enable};
        // Toggle only when the word changes, so the link side never sees it moving
        cfg_tog_d = cfg_tog_q ^ (lcfg_src_d != lcfg_src_q);
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            DUTY_STAB_ON <= CFG_RESET.duty_stabiliser_enable;
            SWING_NORMAL <= CFG_RESET.output_swing_select;
            LOW_FREQ_ADJ <= EXT_RESET.interleave_low_freq_enable;
            SAMPLE_CLK_INVERT <= ADJ_RESET.sample_clock_invert;
            APERTURE_DELAY_PS <= DELAY_RESET;
            FINE_DELAY <= ADJ_RESET.fine_field;
            I_CHAN <= CHAN_RESET;
            Q_CHAN <= CHAN_RESET;
            SYNTH_POWER_DOWN <= 1'b0;
            lcfg_src_q <= LINK_CFG_RESET;
            cfg_tog_q <= 1'b0;
        end else begin
            DUTY_STAB_ON <= eff.duty_stabiliser_enable;
            SWING_NORMAL <= eff.output_swing_select;
            LOW_FREQ_ADJ <= ext_q.interleave_low_freq_enable;
            SAMPLE_CLK_INVERT <= adj_q.sample_clock_invert;
            APERTURE_DELAY_PS <= delay_d;
            FINE_DELAY <= adj_q.fine_field;
            I_CHAN <= ich_q;
            Q_CHAN <= qch_q;
            SYNTH_POWER_DOWN <= pin_s2_q[3];
            lcfg_src_q <= lcfg_src_d;
            cfg_tog_q <= cfg_tog_d;
        end
    end

    // ------------------------------------------------------------
    // Calibration sequencer
    // ------------------------------------------------------------
    cal_e cal_q, cal_d;
    logic [15:0] cal_cnt_q, cal_cnt_d;
    logic pend_q, pend_d;
    logic clk_hold_d, clk_hold_q;

    always_comb begin
        cal_d = cal_q;
        cal_cnt_d = cal_cnt_q;
        pend_d = pend_q | CAL_START;
        unique case (cal_q)
            CAL_IDLE: begin
                if (pend_q) begin
                    pend_d = CAL_START;
                    cal_cnt_d = '0;
                    cal_d = ext_q.termination_trim_disable ? CAL_CORE : CAL_TRIM;
                end
            end
            CAL_TRIM: begin
                cal_cnt_d = cal_cnt_q + 16'h0001;
                if (cal_cnt_q == 16'(CAL_TRIM_CYCLES - 1)) begin
                    cal_cnt_d = '0;
                    cal_d = CAL_CORE;
                end
            end
            CAL_CORE: begin
                cal_cnt_d = cal_cnt_q + 16'h0001;
                if (cal_cnt_q == 16'(CAL_CORE_CYCLES - 1)) begin
                    cal_cnt_d = '0;
                    cal_d = CAL_IDLE;
                end
            end
        endcase
        // Data clock stops for the whole cycle unless trim is disabled
        clk_hold_d = (cal_d != CAL_IDLE) && !ext_q.termination_trim_disable;
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            cal_q <= CAL_IDLE;
            cal_cnt_q <= '0;
            pend_q <= 1'b1;
            clk_hold_q <= 1'b0;
            CAL_BUSY <= 1'b0;
            TRIM_ACTIVE <= 1'b0;
        end else begin
            cal_q <= cal_d;
            cal_cnt_q <= cal_cnt_d;
            pend_q <= pend_d;
            clk_hold_q <= clk_hold_d;
            CAL_BUSY <= cal_d != CAL_IDLE;
            TRIM_ACTIVE <= cal_d == CAL_TRIM;
        end
    end

    // ------------------------------------------------------------
    // Link domain: crossing
    // ------------------------------------------------------------
    logic tog_s1_q, tog_s2_q, tog_s3_q, hold_s1_q, hold_s2_q;
    link_cfg_s lcfg_q, lcfg_d;
    always_comb begin
        lcfg_d = (tog_s2_q != tog_s3_q) ? lcfg_src_q : lcfg_q;
    end
    always_ff @(posedge LINK_CLK or negedge RESETN) begin
        if (!RESETN) begin
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_s3_q <= 1'b0;
            hold_s1_q <= 1'b0;
            hold_s2_q <= 1'b0;
            lcfg_q <= LINK_CFG_RESET;
        end else begin
            tog_s1_q <= cfg_tog_q;
            tog_s2_q <= tog_s1_q;
            tog_s3_q <= tog_s2_q;
            hold_s1_q <= clk_hold_q;
            hold_s2_q <= hold_s1_q;
            lcfg_q <= lcfg_d;
        end
    end

    // ------------------------------------------------------------
    // Link domain: output bus
    // ------------------------------------------------------------
    logic ddr, nondemux, oclk_d, load, half_q, half_d, ovr_pin;
    logic [7:0] tp_q, tp_d, i_w, q_w, i_hold_q, i_hold_d, q_hold_q, q_hold_d;
    logic [15:0] i_bus_d, q_bus_d;
    logic [1:0] ovr_d;

    always_comb begin
        ddr = !lcfg_q.double_rate_disable;
        nondemux = lcfg_q.edge_and_demux_select;
        oclk_d = hold_s2_q ? 1'b0 : !OCLK_A;
        // One word per edge in double rate, per selected edge in single rate
        load = !hold_s2_q && (ddr || (oclk_d == lcfg_q.edge_and_demux_select));
        tp_d = (load && lcfg_q.test_pattern_enable) ? tp_q + 8'h01 : tp_q;
        i_w = lcfg_q.test_pattern_enable ? tp_q : I_SAMPLE;
        q_w = lcfg_q.test_pattern_enable ? ~tp_q : Q_SAMPLE;
        ovr_d[0] = (I_SAMPLE == CODE_MAX) || (I_SAMPLE == CODE_MIN);
        ovr_d[1] = (Q_SAMPLE == CODE_MAX) || (Q_SAMPLE == CODE_MIN);
        if (lcfg_q.test_pattern_enable) begin
            ovr_d = {2{tp_q[0]}};
        end
        ovr_pin = ovr_d[0] | ovr_d[1];
        half_d = half_q;
        i_hold_d = i_hold_q;
        q_hold_d = q_hold_q;
        i_bus_d = I_BUS;
        q_bus_d = Q_BUS;
        if (load) begin
            if (ddr && !nondemux) begin
                // Demultiplexed: two words leave together every second slot
                half_d = !half_q;
                i_hold_d = i_w;
                q_hold_d = q_w;
                if (half_q) begin
                    i_bus_d = {i_w, i_hold_q};
                    q_bus_d = {q_w, q_hold_q};
                end
            end else begin
                half_d = 1'b0;
                i_bus_d = {8'h00, i_w};
                q_bus_d = {8'h00, q_w};
            end
        end
    end

    always_ff @(posedge LINK_CLK or negedge RESETN) begin
        if (!RESETN) begin
            OCLK_A <= 1'b0;
            OCLK_B_OR <= 1'b0;
            OCLK_CENTRE <= 1'b0;
            I_BUS <= 16'h0000;
            Q_BUS <= 16'h0000;
            OVR_IND <= 2'b00;
            tp_q <= 8'h00;
            half_q <= 1'b0;
            i_hold_q <= 8'h00;
            q_hold_q <= 8'h00;
        end else begin
            OCLK_A <= oclk_d;
            OCLK_B_OR <= lcfg_q.second_clock_disable ? ovr_pin : oclk_d;
            OCLK_CENTRE <= ddr && !nondemux && lcfg_q.ddr_clock_phase_select;
            I_BUS <= i_bus_d;
            Q_BUS <= q_bus_d;
            OVR_IND <= ovr_d;
            tp_q <= tp_d;
            half_q <= half_d;
            i_hold_q <= i_hold_d;
            q_hold_q <= q_hold_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_TRIM_SKIP: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (cal_q == CAL_IDLE && pend_q && ext_q.termination_trim_disable) |=>
            (cal_q == CAL_CORE) [*2])
        else $error("Trim not skipped");
    AST_CORE_ALWAYS: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        $fell(cal_q == CAL_TRIM) |-> cal_q == CAL_CORE)
        else $error("Trim not followed by core calibration");
    AST_DCS: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (CFG_WRITE && !pin_mode) ##1 !pin_mode |=> DUTY_STAB_ON == $past(CFG_IN.duty_stabiliser_enable, 2))
        else $error("Duty stabiliser not applied");
    AST_SYNTH: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        EXT_CLK_SEL [*4] |-> SYNTH_POWER_DOWN)
        else $error("Synthesiser left powered");
    AST_DELAY: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (adj_q.coarse_field == 5'h00) |=> APERTURE_DELAY_PS ==
            12'($past(adj_q.intermediate_delay_field) * MID_STEP_PS))
        else $error("Delay step wrong");
    AST_FS: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        I_CHAN.full_scale_mv >= FS_MIN_MV && I_CHAN.full_scale_mv <= FS_MAX_MV)
        else $error("Full scale out of range");
    AST_DDR_RATE: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
        (ddr && !hold_s2_q && $stable(lcfg_q)) |=> OCLK_A != $past(OCLK_A))
        else $error("Data clock not toggling");
    AST_EDGE_ALIGN: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
        (ddr && nondemux) |=> !OCLK_CENTRE)
        else $error("Centre phase in non-demultiplexed mode");
    AST_SECOND: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
        !lcfg_q.second_clock_disable |=> OCLK_B_OR == OCLK_A)
        else $error("Second clock differs");
    AST_TP: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
        (lcfg_q.test_pattern_enable && load && !ddr) |=> I_BUS[7:0] == $past(tp_q))
        else $error("Test pattern missing");
    AST_Q_FS: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        Q_CHAN.full_scale_mv >= FS_MIN_MV && Q_CHAN.full_scale_mv <= FS_MAX_MV)
        else $error("Q full scale out of range");
    AST_SWING: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        !pin_mode |=> SWING_NORMAL == $past(cfg_q.output_swing_select))
        else $error("Swing not applied");
    AST_HOLD_CLK: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
        hold_s2_q |=> !OCLK_A)
        else $error("Data clock running during trim");
    AST_SDR_EDGE: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
        (!ddr && load) |=> OCLK_A == $past(lcfg_q.edge_and_demux_select))
        else $error("Single-rate word on wrong edge");
    AST_DDR_WORD: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
        (ddr && nondemux && load && !lcfg_q.test_pattern_enable) |=>
            I_BUS == {8'h00, $past(I_SAMPLE)})
        else $error("Double-rate word not passed");
    AST_OVR_TP: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
        lcfg_q.test_pattern_enable |=> OVR_IND == {2{$past(tp_q[0])}})
        else $error("Over-range not on pattern");
endmodule

/* sim/capture_model.sv */
`timescale 1ns/100ps
module capture_model (
    input wire logic LINK_CLK,
    input wire logic OCLK_A,
    input wire logic [15:0] I_BUS,
    input wire logic CLEAR
);
    // ------------------------------------------------------------
    // Word and clock-edge counters of the capture side
    // ------------------------------------------------------------
    int words;
    int toggles;
    logic edge_at_word;
    logic [15:0] prev_q;
    logic oclk_q;

    // Sampled mid-cycle, away from the launching edge
    always @(negedge LINK_CLK) begin
        if (CLEAR) begin
            words = 0;
            toggles = 0;
        end else begin
            if (I_BUS !== prev_q) begin
                words++;
                edge_at_word = OCLK_A;
            end
            if (OCLK_A !== oclk_q) begin
                toggles++;
            end
        end
        prev_q = I_BUS;
        oclk_q = OCLK_A;
    end
endmodule

/* sim/test_adc_output_config_regs.sv */
`timescale 1ns/100ps
module test_adc_output_config_regs;
    import outcfg_pkg::*;
    // ------------------------------------------------------------
    // Signals and counters
    // ------------------------------------------------------------
    localparam int CS = 100;
    logic sys_clk, link_clk, resetn, strap_n, edge_pin, swing_pin, clr, ramp;
    logic cfg_wr, ext_wr, ich_wr, qch_wr, adj_wr, cal_start, ext_clk_sel;
    cfg_s cfg_in;
    ext_s ext_in;
    chan_s ich_in, qch_in, i_chan, q_chan;
    adj_s adj_in;
    logic [7:0] i_sample, q_sample;
    logic duty_on, swing_normal, low_freq, clk_inv, synth_pd, cal_busy, trim_active;
    logic oclk_a, oclk_b_or, oclk_centre;
    logic [11:0] aperture;
    logic [5:0] fine;
    logic [15:0] i_bus, q_bus;
    logic [1:0] ovr_ind;
    int mismatches, checked, cycles;

    adc_output_config_regs #(.COARSE_STEP_PS(CS), .CAL_TRIM_CYCLES(4),
        .CAL_CORE_CYCLES(8)) dut (
        .SYS_CLK(sys_clk), .RESETN(resetn), .LINK_CLK(link_clk),
        .EXT_CTRL_STRAP_N(strap_n), .OUTPUT_EDGE_PIN(edge_pin),
        .OUTPUT_SWING_PIN(swing_pin), .CFG_IN(cfg_in), .CFG_WRITE(cfg_wr),
        .EXT_IN(ext_in), .EXT_WRITE(ext_wr), .ICH_IN(ich_in), .ICH_WRITE(ich_wr),
        .QCH_IN(qch_in), .QCH_WRITE(qch_wr), .ADJ_IN(adj_in), .ADJ_WRITE(adj_wr),
        .CAL_START(cal_start), .EXT_CLK_SEL(ext_clk_sel), .I_SAMPLE(i_sample),
        .Q_SAMPLE(q_sample), .DUTY_STAB_ON(duty_on), .SWING_NORMAL(swing_normal),
        .LOW_FREQ_ADJ(low_freq), .SAMPLE_CLK_INVERT(clk_inv),
        .APERTURE_DELAY_PS(aperture), .FINE_DELAY(fine), .I_CHAN(i_chan),
        .Q_CHAN(q_chan), .SYNTH_POWER_DOWN(synth_pd), .CAL_BUSY(cal_busy),
        .TRIM_ACTIVE(trim_active), .OCLK_A(oclk_a), .OCLK_B_OR(oclk_b_or),
        .OCLK_CENTRE(oclk_centre), .I_BUS(i_bus), .Q_BUS(q_bus), .OVR_IND(ovr_ind)
    );
    capture_model cap (.LINK_CLK(link_clk), .OCLK_A(oclk_a), .I_BUS(i_bus), .CLEAR(clr));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // Odd offset keeps the two clocks apart in phase
    initial begin
        link_clk = 1'b0;
        #3.7;
        forever #6 link_clk = ~link_clk;
    end
    always @(negedge link_clk) begin
        if (ramp) begin
            i_sample <= i_sample + 8'h01;
        end
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task check(input string what, input logic [18:0] exp, input logic [18:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic pulse(ref logic s);
        @(negedge sys_clk);
        s = 1'b1;
        @(negedge sys_clk);
        s = 1'b0;
        repeat (3) @(negedge sys_clk);
    endtask
    // Link side lags by a few link cycles, then a fresh count window
    task settle();
        repeat (4) @(negedge sys_clk);
        @(posedge link_clk);
        clr = 1'b1;
        @(posedge link_clk);
        clr = 1'b0;
        repeat (10) @(negedge sys_clk);
    endtask
    task set_cfg(input logic [5:0] v);
        cfg_in = v;
        pulse(cfg_wr);
        settle();
    endtask
    task automatic calibrate(input logic trim_exp);
        int busy_n, trim_n, dchg;
        logic last;
        busy_n = 0;
        trim_n = 0;
        dchg = 0;
        last = oclk_a;
        @(negedge sys_clk);
        cal_start = 1'b1;
        @(negedge sys_clk);
        cal_start = 1'b0;
        for (int n = 0; n < 200; n++) begin
            @(negedge sys_clk);
            busy_n += (cal_busy === 1'b1);
            trim_n += (trim_active === 1'b1);
            dchg += (cal_busy === 1'b1 && oclk_a !== last);
            last = oclk_a;
        end
        check("cal_len", 1, busy_n >= 8);
        check("trim_seen", trim_exp, trim_n > 0);
        check("cal_done", 0, cal_busy);
        if (!trim_exp) begin
            check("oclk_run", 1, dchg > 0);
        end else begin
            // Link side needs a few of its cycles to see the hold
            check("oclk_held", 1, dchg <= 2);
        end
    endtask
    task give_verdict();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset();
        repeat (2) @(negedge sys_clk);
        check("cal_busy", 1, cal_busy);
        check("duty_on", 1, duty_on);
        check("swing", 1, swing_normal);
        check("i_fs", 19'(FS_RESET_MV), i_chan.full_scale_mv);
        check("q_fs", 19'(FS_RESET_MV), q_chan.full_scale_mv);
        for (int n = 0; n < 300 && cal_busy !== 1'b0; n++) @(negedge sys_clk);
        check("cal_idle", 0, cal_busy);
        $display("test reset done");
    endtask
    task t_modes();
        set_cfg(6'b000101);
        check("duty_on", 0, duty_on);
        check("swing", 0, swing_normal);
        check("oclk_b", oclk_a, oclk_b_or);
        check("sdr_rate", 1, cap.words > 4 && cap.toggles >= 2 * cap.words - 2
            && cap.toggles <= 2 * cap.words + 2);
        check("sdr_edge", 1, cap.edge_at_word);
        set_cfg(6'b000100);
        check("sdr_edge", 0, cap.edge_at_word);
        set_cfg(6'b011001);
        check("ddr_rate", 1, cap.words > 4 && cap.toggles >= cap.words - 2
            && cap.toggles <= cap.words + 2);
        check("centre", 0, oclk_centre);
        set_cfg(6'b011000);
        check("centre", 1, oclk_centre);
        check("demux", 8'(i_bus[7:0] + 8'h01), i_bus[15:8]);
        set_cfg(6'b010000);
        check("centre", 0, oclk_centre);
        set_cfg(6'b011100);
        check("centre", 0, oclk_centre);
        ramp = 1'b0;
        i_sample = CODE_MAX;
        q_sample = CODE_MAX;
        set_cfg(6'b110111);
        check("ovr_out", 1, oclk_b_or);
        check("ovr_ind", 2'b11, ovr_ind);
        i_sample = 8'h40;
        q_sample = 8'h40;
        settle();
        check("ovr_out", 0, oclk_b_or);
        check("ovr_ind", 2'b00, ovr_ind);
        ramp = 1'b1;
        set_cfg(6'b011001);
        $display("test modes done");
    endtask
    task t_ext();
        ext_in = 3'b101;
        pulse(ext_wr);
        settle();
        check("low_freq", 1, low_freq);
        check("pattern", 8'(~q_bus[7:0]), i_bus[7:0]);
        ext_in = 3'b010;
        pulse(ext_wr);
        check("low_freq", 0, low_freq);
        calibrate(1'b0);
        ext_in = 3'b000;
        pulse(ext_wr);
        calibrate(1'b1);
        $display("test extended done");
    endtask
    task t_chan();
        ich_in = '{1'b1, 8'hFF, 10'd900};
        pulse(ich_wr);
        check("i_chan", {1'b1, 8'hFF, FS_MAX_MV}, i_chan);
        qch_in = '{1'b0, 8'h00, 10'd500};
        pulse(qch_wr);
        check("q_chan", {1'b0, 8'h00, FS_MIN_MV}, q_chan);
        calibrate(1'b1);
        $display("test channel done");
    endtask
    task t_adj();
        adj_in = '{1'b1, 5'd3, 3'd5, 6'h2A};
        pulse(adj_wr);
        check("invert", 1, clk_inv);
        check("aperture", 19'(3 * CS + 5 * MID_STEP_PS), aperture);
        check("fine", 6'h2A, fine);
        adj_in = '{1'b0, 5'd0, 3'd0, 6'h3F};
        pulse(adj_wr);
        check("invert", 0, clk_inv);
        check("aperture", 0, aperture);
        adj_in = '{1'b0, 5'd31, 3'd7, 6'h00};
        pulse(adj_wr);
        check("aperture", 19'(MAX_DELAY_PS), aperture);
        $display("test adjust done");
    endtask
    task t_source();
        ext_clk_sel = 1'b1;
        repeat (5) @(negedge sys_clk);
        check("synth_pd", 1, synth_pd);
        ext_clk_sel = 1'b0;
        repeat (5) @(negedge sys_clk);
        check("synth_pd", 0, synth_pd);
        calibrate(1'b1);
        strap_n = 1'b1;
        swing_pin = 1'b1;
        cfg_in = 6'b000000;
        pulse(cfg_wr);
        repeat (4) @(negedge sys_clk);
        check("swing_pin", 1, swing_normal);
        check("duty_on", 1, duty_on);
        check("pin_demux", 8'(i_bus[7:0] + 8'h01), i_bus[15:8]);
        swing_pin = 1'b0;
        edge_pin = 1'b1;
        repeat (6) @(negedge sys_clk);
        check("swing_pin", 0, swing_normal);
        check("pin_nondemux", 0, i_bus[15:8]);
        strap_n = 1'b0;
        edge_pin = 1'b0;
        $display("test source done");
    endtask

    initial begin
        {mismatches, checked, cycles} = '0;
        {resetn, edge_pin, swing_pin, clr, cfg_wr, ext_wr} = '0;
        {ich_wr, qch_wr, adj_wr, cal_start, ext_clk_sel} = '0;
        strap_n = 1'b0;
        ramp = 1'b1;
        cfg_in = CFG_RESET;
        ext_in = EXT_RESET;
        ich_in = CHAN_RESET;
        qch_in = CHAN_RESET;
        adj_in = ADJ_RESET;
        i_sample = 8'h10;
        q_sample = 8'h40;
        repeat (3) @(negedge sys_clk);
        resetn = 1'b1;
        t_reset();
        t_modes();
        t_ext();
        t_chan();
        t_adj();
        t_source();
        give_verdict();
    end
endmodule
